// ---- src/usbh_pkg.sv ----
// Shared constants and types of the endpoint controller.
// Assumes a device register port with one control/status word and one
// FIFO data port per endpoint, eight bits wide, on the controller clock.
package usbh_pkg;
  // Own Wishbone register offsets (byte addresses).
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SETUP_LO = 8'h08;
  localparam logic [7:0] OFS_SETUP_HI = 8'h0C;
  localparam logic [7:0] OFS_TX_LO = 8'h10;
  localparam logic [7:0] OFS_TX_HI = 8'h14;
  // Command word fields.
  localparam int CMD_SETUP_BIT = 0;
  localparam int CMD_IN_BIT = 1;
  localparam int CMD_STALL_BIT = 2;
  localparam int CMD_LAST_BIT = 3;
  localparam int CMD_ISO_BIT = 4;
  localparam int CMD_ADVANCE_BIT = 5;
  localparam int CMD_EP_LSB = 8;
  localparam int CMD_LEN_LSB = 16;
  // Status word fields.
  localparam int STS_ERR_BIT = 1;
  // Device port address: {endpoint, select}.
  localparam logic DEV_SEL_CSR = 1'h0;
  localparam logic DEV_SEL_FIFO = 1'h1;
  // Device control/status word bit positions.
  localparam int CSR_COMP_BIT = 0;
  localparam int CSR_SETUP_BIT = 2;
  localparam int CSR_STALL_BIT = 3;
  localparam int CSR_TXRDY_BIT = 4;
  // Endpoints with two banks; bit n stands for endpoint n.
  localparam logic [7:0] DUAL_BANK_MASK = 8'h34;
  localparam logic [2:0] DEFAULT_EP = 3'h0;
  localparam logic [3:0] SETUP_LEN = 4'h8;
  localparam logic [3:0] MAX_LEN = 4'h8;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_SU_POLL = 10'h002,
    ST_SU_READ = 10'h004,
    ST_SU_CLEAR = 10'h008,
    ST_IN_POLL = 10'h010,
    ST_IN_WRITE = 10'h020,
    ST_IN_ARM = 10'h040,
    ST_IN_WAIT = 10'h080,
    ST_IN_CLEAR = 10'h100,
    ST_STALL = 10'h200
  } usbh_state_type;

  typedef enum logic [4:0] {
    STG_IDLE = 5'h01,
    STG_DATA_IN = 5'h02,
    STG_DATA_OUT = 5'h04,
    STG_STATUS_IN = 5'h08,
    STG_STATUS_OUT = 5'h10
  } usbh_stage_type;
endpackage : usbh_pkg

// ---- src/usbh_acc_if.sv ----
// Single device register access request between sequencer and pin driver.
// Assumes one request at a time; req is a one-cycle pulse.
`timescale 1ns/1ps
interface usbh_acc_if;
  logic req;
  logic wr;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic done;
  modport ctrl (output req, output wr, output addr, output wdata, input rdata, input done);
  modport port (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface : usbh_acc_if

// ---- src/usbh_dev_port.sv ----
// Drives the device register pins for one access at a time.
// Assumes the device answers with a one-cycle ack on the same clock.
`timescale 1ns/1ps
module usbh_dev_port (
  input wire logic clk_i,
  input wire logic rst_i,
  usbh_acc_if.port acc,
  output logic dev_req_o,
  output logic dev_wr_o,
  output logic [3:0] dev_addr_o,
  output logic [7:0] dev_wdata_o,
  input wire logic [7:0] dev_rdata_i,
  input wire logic dev_ack_i
);
  logic [7:0] rdata;
  logic done;

  // Request fields stay frozen until the ack, so the device sees stable pins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dev_req_o <= 1'b0;
      dev_wr_o <= 1'b0;
      dev_addr_o <= 4'h0;
      dev_wdata_o <= 8'h00;
    end
    else if (acc.req && !dev_req_o)
    begin
      dev_req_o <= 1'b1;
      dev_wr_o <= acc.wr;
      dev_addr_o <= acc.addr;
      dev_wdata_o <= acc.wdata;
    end
    else if (dev_req_o && dev_ack_i)
    begin
      dev_req_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      done <= dev_req_o && dev_ack_i;
      if (dev_req_o && dev_ack_i)
      begin
        rdata <= dev_rdata_i;
      end
    end
  end

  assign acc.done = done;
  assign acc.rdata = rdata;
endmodule : usbh_dev_port

// ---- src/usbh_byte_buf.sv ----
// Eight-byte flip-flop buffer with a byte write port and a word write port.
// Assumes the two write ports are never used in the same cycle.
`timescale 1ns/1ps
module usbh_byte_buf (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic byte_we_i,
  input wire logic [2:0] byte_idx_i,
  input wire logic [7:0] byte_i,
  input wire logic word_we_i,
  input wire logic word_idx_i,
  input wire logic [3:0] word_sel_i,
  input wire logic [31:0] word_i,
  output logic [63:0] bytes_o
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_byte
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          bytes_o[8*i +: 8] <= 8'h00;
        end
        else if (byte_we_i && byte_idx_i == 3'(i))
        begin
          bytes_o[8*i +: 8] <= byte_i;
        end
        else if (word_we_i && word_idx_i == 1'(i / 4) && word_sel_i[i % 4])
        begin
          bytes_o[8*i +: 8] <= word_i[8*(i%4) +: 8];
        end
      end
    end
  endgenerate
endmodule : usbh_byte_buf

// ---- src/usbh_ep_ctrl.sv ----
// Endpoint controller: plays the firmware side of a USB device endpoint.
// Assumes a Wishbone classic master above and the device register pins below,
// both on clk_i; the device is logic on the same clock, so no synchronisers.
// Function
// [RULE_01] Control transfers only on single-bank endpoints
// [RULE_02] Isochronous transfers only on dual-bank endpoints
// [RULE_03] Stall aborts an ongoing control transfer
// [RULE_04] Control stages follow one of three orders
// [RULE_05] Status IN stage sends zero-length DATA1 packet
// [RULE_06] Host sends zero-length OUT in status OUT
// [RULE_07] Device acknowledges setup packets by itself
// [RULE_08] Setup sets flag and fills endpoint FIFO
// [RULE_09] Interrupt pending while setup flag set
// [RULE_10] Read whole setup packet before clearing flag
// [RULE_11] Cleared setup flag frees FIFO for OUT
// [RULE_12] Check transmit-ready clear before FIFO writes
// [RULE_13] Load IN packet byte by byte, maybe empty
// [RULE_14] Set transmit-ready after the FIFO writes
// [RULE_15] Device sets transmit-complete on host ACK
// [RULE_16] Interrupt pending while transmit-complete set
// [RULE_17] Next packet: write, arm, then clear complete
// [RULE_18] Clear transmit-complete after the final packet
// [RULE_19] Endpoint zero is the control endpoint; code resets ctl_ep to it, a setup command moves ctl_ep to its endpoint
// [RULE_20] FIFO reached by single byte accesses
// [RULE_21] Device runs master and 48 MHz clocks
// [RULE_22] Device NAKs IN while transmit-ready clear
`timescale 1ns/1ps
module usbh_ep_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic dev_req_o,
  output logic dev_wr_o,
  output logic [3:0] dev_addr_o,
  output logic [7:0] dev_wdata_o,
  input wire logic [7:0] dev_rdata_i,
  input wire logic dev_ack_i
);
  usbh_acc_if acc ();

  usbh_pkg::usbh_state_type state;
  usbh_pkg::usbh_stage_type stage;
  logic wait_acc;
  logic acc_req;
  logic [3:0] byte_idx;
  logic [2:0] ep;
  logic [2:0] ctl_ep;
  logic [3:0] len;
  logic last;
  logic comp_pending;
  logic keep_rdy;
  logic [7:0] csr;
  logic err;
  logic [63:0] setup_bytes;
  logic [63:0] tx_bytes;
  logic [7:0] wdata;

  // Bus decode.
  logic wb_hit;
  logic wr_cmd;
  logic wr_status;
  logic wr_tx;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = wb_hit && wb_we_i && wb_adr_i == usbh_pkg::OFS_CMD && wb_sel_i == 4'hF;
  assign wr_status = wb_hit && wb_we_i && wb_adr_i == usbh_pkg::OFS_STATUS && wb_sel_i[0];
  assign wr_tx = wb_hit && wb_we_i
    && (wb_adr_i == usbh_pkg::OFS_TX_LO || wb_adr_i == usbh_pkg::OFS_TX_HI);

  // Command fields.
  logic c_setup;
  logic c_in;
  logic c_stall;
  logic c_adv;
  logic c_iso;
  logic [2:0] c_ep;
  logic [3:0] c_len;
  logic c_dual;
  logic c_ctl;
  logic c_bad;
  logic busy;
  assign c_setup = wb_dat_i[usbh_pkg::CMD_SETUP_BIT];
  assign c_in = wb_dat_i[usbh_pkg::CMD_IN_BIT];
  assign c_stall = wb_dat_i[usbh_pkg::CMD_STALL_BIT];
  assign c_adv = wb_dat_i[usbh_pkg::CMD_ADVANCE_BIT];
  assign c_iso = wb_dat_i[usbh_pkg::CMD_ISO_BIT];
  assign c_ep = wb_dat_i[usbh_pkg::CMD_EP_LSB +: 3];
  assign c_len = wb_dat_i[usbh_pkg::CMD_LEN_LSB +: 4];
  assign c_dual = usbh_pkg::DUAL_BANK_MASK[c_ep];
  assign c_ctl = c_ep == ctl_ep;
  assign busy = state != usbh_pkg::ST_IDLE;

  // Bad commands are refused whole; nothing reaches the device for them.
  always_comb
  begin
    c_bad = 1'b0;
    if ((c_setup || c_stall || c_adv) && c_dual)
    begin
      c_bad = 1'b1; // [RULE_01]
    end
    if (c_in && c_iso && !c_dual)
    begin
      c_bad = 1'b1; // [RULE_02]
    end
    if (c_in && c_ctl && (stage == usbh_pkg::STG_DATA_OUT
        || stage == usbh_pkg::STG_STATUS_OUT))
    begin
      c_bad = 1'b1; // [RULE_04]
    end
    if (c_adv && !(stage == usbh_pkg::STG_DATA_OUT || stage == usbh_pkg::STG_STATUS_OUT))
    begin
      c_bad = 1'b1; // [RULE_04]
    end
    if (c_in && c_len > usbh_pkg::MAX_LEN)
    begin
      c_bad = 1'b1;
    end
    if (4'(c_setup) + 4'(c_in) + 4'(c_stall) + 4'(c_adv) != 4'h1)
    begin
      c_bad = 1'b1;
    end
  end

  logic go;
  assign go = wr_cmd && !busy && !c_bad;

  // Wishbone slave: one wait state, unmapped reads give zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      case (wb_adr_i)
        usbh_pkg::OFS_STATUS: wb_dat_o <= {8'h00, csr, 5'h00, ctl_ep, comp_pending,
                                           stage, err, busy};
        usbh_pkg::OFS_SETUP_LO: wb_dat_o <= setup_bytes[31:0];
        usbh_pkg::OFS_SETUP_HI: wb_dat_o <= setup_bytes[63:32];
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // A refused command in the same cycle as a clear keeps the error set.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      err <= 1'b0;
    end
    else if (wr_cmd && (busy || c_bad))
    begin
      err <= 1'b1;
    end
    else if (wr_status && wb_dat_i[usbh_pkg::STS_ERR_BIT])
    begin
      err <= 1'b0;
    end
  end

  // Device access fields follow the state.
  logic st_wr;
  logic st_fifo;
  assign st_wr = state == usbh_pkg::ST_SU_CLEAR || state == usbh_pkg::ST_IN_WRITE
    || state == usbh_pkg::ST_IN_ARM || state == usbh_pkg::ST_IN_CLEAR
    || state == usbh_pkg::ST_STALL;
  assign st_fifo = state == usbh_pkg::ST_SU_READ || state == usbh_pkg::ST_IN_WRITE; // [RULE_20]

  // Flags that clear on a written zero are written as one to leave them.
  always_comb
  begin
    wdata = 8'h00;
    case (state)
      usbh_pkg::ST_IN_WRITE:
      begin
        wdata = tx_bytes[{byte_idx[2:0], 3'h0} +: 8]; // [RULE_13]
      end
      usbh_pkg::ST_SU_CLEAR:
      begin
        wdata[usbh_pkg::CSR_COMP_BIT] = 1'b1; // [RULE_10]
      end
      usbh_pkg::ST_IN_ARM:
      begin
        wdata[usbh_pkg::CSR_TXRDY_BIT] = 1'b1; // [RULE_14]
        wdata[usbh_pkg::CSR_COMP_BIT] = 1'b1;
        wdata[usbh_pkg::CSR_SETUP_BIT] = 1'b1;
      end
      usbh_pkg::ST_IN_CLEAR:
      begin
        wdata[usbh_pkg::CSR_TXRDY_BIT] = keep_rdy; // [RULE_17]
        wdata[usbh_pkg::CSR_SETUP_BIT] = 1'b1;
      end
      usbh_pkg::ST_STALL:
      begin
        wdata[usbh_pkg::CSR_STALL_BIT] = 1'b1; // [RULE_03]
        wdata[usbh_pkg::CSR_COMP_BIT] = 1'b1;
        wdata[usbh_pkg::CSR_SETUP_BIT] = 1'b1;
      end
      default:
      begin
        wdata = 8'h00;
      end
    endcase
  end

  assign acc.req = acc_req;
  assign acc.wr = st_wr;
  assign acc.addr = {ep, st_fifo ? usbh_pkg::DEV_SEL_FIFO : usbh_pkg::DEV_SEL_CSR};
  assign acc.wdata = wdata;

  logic rd_setup;
  logic rd_comp;
  logic rd_rdy;
  logic last_byte;
  assign rd_setup = acc.rdata[usbh_pkg::CSR_SETUP_BIT];
  assign rd_comp = acc.rdata[usbh_pkg::CSR_COMP_BIT];
  assign rd_rdy = acc.rdata[usbh_pkg::CSR_TXRDY_BIT];
  assign last_byte = byte_idx + 4'h1 == len;

  // Sequencer: every non-idle state issues one access and acts on its answer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= usbh_pkg::ST_IDLE;
      wait_acc <= 1'b0;
      acc_req <= 1'b0;
      byte_idx <= 4'h0;
      ep <= usbh_pkg::DEFAULT_EP;
      len <= 4'h0;
      last <= 1'b0;
      comp_pending <= 1'b0;
      keep_rdy <= 1'b0;
    end
    else
    begin
      acc_req <= 1'b0;
      if (state == usbh_pkg::ST_IDLE)
      begin
        if (go && !c_adv)
        begin
          ep <= c_ep;
          byte_idx <= 4'h0;
          len <= c_len;
          last <= wb_dat_i[usbh_pkg::CMD_LAST_BIT];
          if (c_setup)
          begin
            state <= usbh_pkg::ST_SU_POLL;
          end
          else if (c_stall)
          begin
            state <= usbh_pkg::ST_STALL;
          end
          else
          begin
            state <= usbh_pkg::ST_IN_POLL;
            if (c_ctl && stage == usbh_pkg::STG_STATUS_IN)
            begin
              len <= 4'h0; // [RULE_05]
              last <= 1'b1;
            end
          end
        end
      end
      else if (!wait_acc)
      begin
        acc_req <= 1'b1;
        wait_acc <= 1'b1;
      end
      else if (acc.done)
      begin
        wait_acc <= 1'b0;
        case (state)
          usbh_pkg::ST_SU_POLL:
          begin
            if (rd_setup)
            begin
              state <= usbh_pkg::ST_SU_READ; // [RULE_08]
            end
          end
          usbh_pkg::ST_SU_READ:
          begin
            byte_idx <= byte_idx + 4'h1;
            if (byte_idx + 4'h1 == usbh_pkg::SETUP_LEN)
            begin
              state <= usbh_pkg::ST_SU_CLEAR; // [RULE_10]
            end
          end
          usbh_pkg::ST_IN_POLL:
          begin
            if (!rd_rdy && (!comp_pending || rd_comp)) // [RULE_12]
            begin
              state <= len == 4'h0 ? usbh_pkg::ST_IN_ARM : usbh_pkg::ST_IN_WRITE;
            end
          end
          usbh_pkg::ST_IN_WRITE:
          begin
            byte_idx <= byte_idx + 4'h1;
            if (last_byte)
            begin
              state <= usbh_pkg::ST_IN_ARM; // [RULE_14]
            end
          end
          usbh_pkg::ST_IN_ARM:
          begin
            if (comp_pending)
            begin
              keep_rdy <= 1'b1;
              state <= usbh_pkg::ST_IN_CLEAR; // [RULE_17]
            end
            else if (last)
            begin
              state <= usbh_pkg::ST_IN_WAIT;
            end
            else
            begin
              comp_pending <= 1'b1;
              state <= usbh_pkg::ST_IDLE;
            end
          end
          usbh_pkg::ST_IN_WAIT:
          begin
            if (rd_comp) // [RULE_15]
            begin
              keep_rdy <= 1'b0;
              state <= usbh_pkg::ST_IN_CLEAR;
            end
          end
          usbh_pkg::ST_IN_CLEAR:
          begin
            if (keep_rdy && last)
            begin
              keep_rdy <= 1'b0;
              comp_pending <= 1'b0;
              state <= usbh_pkg::ST_IN_WAIT;
            end
            else
            begin
              comp_pending <= keep_rdy;
              keep_rdy <= 1'b0;
              state <= usbh_pkg::ST_IDLE; // [RULE_18]
            end
          end
          usbh_pkg::ST_STALL:
          begin
            comp_pending <= 1'b0;
            state <= usbh_pkg::ST_IDLE;
          end
          default:
          begin
            state <= usbh_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Last device status word seen, shown to software.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      csr <= 8'h00;
    end
    else if (acc.done && !st_wr && !st_fifo)
    begin
      csr <= acc.rdata;
    end
  end

  logic ev_setup;
  logic ev_in_end;
  logic ev_stall;
  assign ev_setup = acc.done && state == usbh_pkg::ST_SU_CLEAR;
  assign ev_in_end = acc.done && state == usbh_pkg::ST_IN_CLEAR && !keep_rdy;
  assign ev_stall = acc.done && state == usbh_pkg::ST_STALL;

  // Control stage tracker for the endpoint that last took a setup packet.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage <= usbh_pkg::STG_IDLE;
      ctl_ep <= usbh_pkg::DEFAULT_EP; // [RULE_19]
    end
    else if (go && c_setup)
    begin
      ctl_ep <= c_ep;
    end
    else if (ev_setup)
    begin
      if (setup_bytes[63:48] == 16'h0000)
      begin
        stage <= usbh_pkg::STG_STATUS_IN; // [RULE_04]
      end
      else if (setup_bytes[7])
      begin
        stage <= usbh_pkg::STG_DATA_IN;
      end
      else
      begin
        stage <= usbh_pkg::STG_DATA_OUT;
      end
    end
    else if (ev_stall && ep == ctl_ep)
    begin
      stage <= usbh_pkg::STG_IDLE; // [RULE_03]
    end
    else if (ev_in_end && ep == ctl_ep)
    begin
      if (stage == usbh_pkg::STG_DATA_IN)
      begin
        stage <= usbh_pkg::STG_STATUS_OUT; // [RULE_04]
      end
      else if (stage == usbh_pkg::STG_STATUS_IN)
      begin
        stage <= usbh_pkg::STG_IDLE;
      end
    end
    else if (go && c_adv)
    begin
      stage <= stage == usbh_pkg::STG_DATA_OUT ? usbh_pkg::STG_STATUS_IN
               : usbh_pkg::STG_IDLE;
    end
  end

  usbh_byte_buf u_setup_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .byte_we_i(acc.done && state == usbh_pkg::ST_SU_READ),
    .byte_idx_i(byte_idx[2:0]),
    .byte_i(acc.rdata),
    .word_we_i(1'b0),
    .word_idx_i(1'b0),
    .word_sel_i(4'h0),
    .word_i(32'h00000000),
    .bytes_o(setup_bytes)
  );

  usbh_byte_buf u_tx_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .byte_we_i(1'b0),
    .byte_idx_i(3'h0),
    .byte_i(8'h00),
    .word_we_i(wr_tx),
    .word_idx_i(wb_adr_i == usbh_pkg::OFS_TX_HI),
    .word_sel_i(wb_sel_i),
    .word_i(wb_dat_i),
    .bytes_o(tx_bytes)
  );

  usbh_dev_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .acc(acc),
    .dev_req_o(dev_req_o),
    .dev_wr_o(dev_wr_o),
    .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o),
    .dev_rdata_i(dev_rdata_i),
    .dev_ack_i(dev_ack_i)
  );
endmodule : usbh_ep_ctrl

// ---- bench/usbh_dev_model.sv ----
// Behavioural endpoint device with its host, facing the controller's device pins.
// Assumes one request at a time on clk_i; the host only serves endpoint zero.
`timescale 1ns/1ps
module usbh_dev_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_req_i,
  input wire logic dev_wr_i,
  input wire logic [3:0] dev_addr_i,
  input wire logic [7:0] dev_wdata_i,
  output logic [7:0] dev_rdata_o,
  output logic dev_ack_o,
  input wire logic setup_i,
  input wire logic [63:0] setup_data_i,
  output logic [7:0] ep0_csr_o,
  output logic [63:0] sent_o,
  output logic [3:0] sent_len_o,
  output logic irq_o
);
  logic [7:0] csr [8];
  logic [7:0] fifo [8];
  logic [2:0] rp;
  logic [3:0] wp;
  logic [1:0] wait_cnt;
  logic [2:0] host_cnt;
  logic [2:0] ep;
  assign ep = dev_addr_i[3:1];
  assign ep0_csr_o = csr[0];
  assign irq_o = csr[0][0] | csr[0][2];
  always_ff @(posedge clk_i)
  begin
    dev_ack_o <= 1'b0;
    // Read data toggles when not answered, so a late sample never sees a valid byte.
    dev_rdata_o <= ~dev_rdata_o;
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++) csr[i] <= 8'h00;
      rp <= 3'h0;
      wp <= 4'h0;
      wait_cnt <= 2'h0;
      host_cnt <= 3'h0;
      sent_len_o <= 4'h0;
      sent_o <= 64'h0;
      dev_rdata_o <= 8'h00;
    end
    else
    begin
      if (setup_i)
      begin
        for (int i = 0; i < 8; i++) fifo[i] <= setup_data_i[8*i+:8];
        csr[0][2] <= 1'b1;
        rp <= 3'h0;
      end
      // The host is NAKed until the packet is armed, then ACKs it a few cycles later.
      if (csr[0][4])
        host_cnt <= host_cnt + 3'h1;
      if (csr[0][4] && host_cnt == 3'h5)
      begin
        host_cnt <= 3'h0;
        csr[0][4] <= 1'b0;
        csr[0][0] <= 1'b1;
        sent_len_o <= wp;
        wp <= 4'h0;
        for (int i = 0; i < 8; i++) sent_o[8*i+:8] <= fifo[i];
      end
      if (dev_req_i && !dev_ack_o)
        wait_cnt <= wait_cnt + 2'h1;
      if (dev_req_i && !dev_ack_o && wait_cnt == 2'h2)
      begin
        wait_cnt <= 2'h0;
        dev_ack_o <= 1'b1;
        if (!dev_wr_i)
        begin
          dev_rdata_o <= dev_addr_i[0] ? fifo[rp] : csr[ep];
          if (dev_addr_i[0])
            rp <= rp + 3'h1;
        end
        else if (dev_addr_i[0])
        begin
          fifo[wp[2:0]] <= dev_wdata_i;
          wp <= wp + 4'h1;
        end
        else
          csr[ep] <= {csr[ep][7:5], dev_wdata_i[4:3], csr[ep][2] & dev_wdata_i[2],
                      csr[ep][1], csr[ep][0] & dev_wdata_i[0]};
      end
    end
  end
endmodule : usbh_dev_model

// ---- bench/usbh_ep_ctrl_chk.sv ----
// Port-level checker of the endpoint controller, bound into its top module.
// Assumes one clock and the synchronous active-high reset of the design.
`timescale 1ns/1ps
module usbh_ep_ctrl_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dev_req_o,
  input wire logic dev_wr_o,
  input wire logic [3:0] dev_addr_o,
  input wire logic [7:0] dev_wdata_o,
  input wire logic [7:0] dev_rdata_i,
  input wire logic dev_ack_i
);
  logic [7:0] rd_csr;
  logic [3:0] rd_cnt;
  logic armed;
  logic acc;
  assign acc = dev_req_o && dev_ack_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_csr <= 8'h00;
    else if (acc && !dev_wr_o && !dev_addr_o[0])
      rd_csr <= dev_rdata_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (acc && dev_wr_o && !dev_addr_o[0]))
      rd_cnt <= 4'h0;
    else if (acc && !dev_wr_o && dev_addr_o[0] && rd_cnt != 4'hF)
      rd_cnt <= rd_cnt + 4'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (acc && dev_wr_o && dev_addr_o[0]))
      armed <= 1'b0;
    else if (acc && dev_wr_o && !dev_addr_o[0] && dev_wdata_o[4])
      armed <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_csr_wr;
    dev_req_o && dev_wr_o && !dev_addr_o[0];
  endsequence
  sequence s_fifo_wr;
    dev_req_o && dev_wr_o && dev_addr_o[0];
  endsequence
  property p_rst;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> !dev_req_o && !wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  property p_wb_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_wb_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_wb_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  property p_req_hold;
    dev_req_o && !dev_ack_i |=> dev_req_o && $stable(dev_addr_o) && $stable(dev_wr_o)
      && $stable(dev_wdata_o);
  endproperty
  property p_req_drop;
    dev_req_o && dev_ack_i |=> !dev_req_o;
  endproperty
  property p_req_gap;
    $fell(dev_req_o) |-> !dev_req_o [*2];
  endproperty
  property p_fill_when_free;
    s_fifo_wr |-> !rd_csr[4];
  endproperty
  property p_setup_read_all;
    s_csr_wr ##0 (!dev_wdata_o[2] && rd_csr[2]) |-> rd_cnt >= 4'h8;
  endproperty
  property p_clear_after_arm;
    s_csr_wr ##0 (!dev_wdata_o[0] && rd_csr[0]) |-> armed;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_wb_answer: assert property (p_wb_answer) else $error("bus request not acked next cycle");
  a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack longer than one cycle");
  a_wb_cause: assert property (p_wb_cause) else $error("bus ack without request");
  a_req_hold: assert property (p_req_hold) else $error("device request changed early");
  a_req_drop: assert property (p_req_drop) else $error("device request kept after ack");
  a_req_gap: assert property (p_req_gap) else $error("device requests too close");
  a_fill_when_free: assert property (p_fill_when_free) else $error("fifo filled while armed");
  a_setup_read_all: assert property (p_setup_read_all) else $error("setup cleared early");
  a_clear_after_arm: assert property (p_clear_after_arm) else $error("complete cleared early");
endmodule : usbh_ep_ctrl_chk
bind usbh_ep_ctrl usbh_ep_ctrl_chk usbh_ep_ctrl_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dev_req_o, .dev_wr_o,
  .dev_addr_o, .dev_wdata_o, .dev_rdata_i, .dev_ack_i);

// ---- bench/testbench.sv ----
// Self-checking bench: Wishbone tasks drive the controller, a device model answers.
// Assumes the controller package and the checker bound into the design.
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dev_req_o, dev_wr_o, dev_ack_i, setup = 1'b0, irq;
  logic [3:0] dev_addr_o, sent_len;
  logic [7:0] dev_wdata_o, dev_rdata_i, ep0_csr;
  logic [63:0] setup_data = 64'h0, sent;
  logic [31:0] rd;
  int fails = 0;
  int comparisons = 0;
  usbh_ep_ctrl usbh_ep_ctrl_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dev_req_o, .dev_wr_o, .dev_addr_o,
    .dev_wdata_o, .dev_rdata_i, .dev_ack_i);
  usbh_dev_model usbh_dev_model_i (.clk_i(clk_i), .rst_i(rst_i), .dev_req_i(dev_req_o),
    .dev_wr_i(dev_wr_o), .dev_addr_i(dev_addr_o), .dev_wdata_i(dev_wdata_o),
    .dev_rdata_o(dev_rdata_i), .dev_ack_o(dev_ack_i), .setup_i(setup),
    .setup_data_i(setup_data), .ep0_csr_o(ep0_csr), .sent_o(sent), .sent_len_o(sent_len),
    .irq_o(irq));
  initial forever #5 clk_i = ~clk_i;
  task automatic stop_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge; returns one idle cycle after the ack edge.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer
  task automatic wait_idle;
    rd = 32'h1;
    while (rd[0] !== 1'b0)
      wb_xfer(1'b0, usbh_pkg::OFS_STATUS, 32'h0);
  endtask : wait_idle
  task automatic cmd(input logic [31:0] word);
    wb_xfer(1'b1, usbh_pkg::OFS_CMD, word);
    wait_idle();
  endtask : cmd
  task automatic do_setup(input logic [63:0] pkt);
    setup_data <= pkt;
    setup <= 1'b1;
    @(posedge clk_i);
    setup <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    cmd(32'h00000001);
    chk({24'h0, ep0_csr}, 32'h00);
  endtask : do_setup
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_xfer(1'b0, usbh_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h00000004);
    wb_xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    do_setup(64'h0008000001000680);
    wb_xfer(1'b0, usbh_pkg::OFS_SETUP_LO, 32'h0);
    chk(rd, 32'h01000680);
    wb_xfer(1'b0, usbh_pkg::OFS_SETUP_HI, 32'h0);
    chk(rd, 32'h00080000);
    wb_xfer(1'b0, usbh_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h7F, 32'h08);
    wb_xfer(1'b1, usbh_pkg::OFS_TX_LO, 32'h44332211);
    cmd(32'h0004000A);
    chk({28'h0, sent_len}, 32'h4);
    chk(sent[31:0], 32'h44332211);
    chk({24'h0, ep0_csr}, 32'h00);
    cmd(32'h00000020);
    chk(rd & 32'h7F, 32'h04);
    do_setup(64'h0000000000000500);
    wb_xfer(1'b0, usbh_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h7F, 32'h20);
    cmd(32'h0000000A);
    chk({28'h0, sent_len}, 32'h0);
    cmd(32'h00000201);
    chk(rd & 32'h2, 32'h2);
    wb_xfer(1'b1, usbh_pkg::OFS_STATUS, 32'h2);
    wb_xfer(1'b0, usbh_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h0);
    cmd(32'h00000112);
    chk(rd & 32'h2, 32'h2);
    cmd(32'h00000004);
    chk({24'h0, ep0_csr}, 32'h08);
    stop_test();
  end
endmodule : testbench
